// ---- include/pvt_timing_map.vh ----
// Named constants for the parallel video source timing generator
`ifndef PVT_TIMING_MAP_VH
`define PVT_TIMING_MAP_VH

`define PVT_CLK_PERIOD_NS 40
`define PVT_RESET_LOW_NS 1250
`define PVT_EYE_GUARD_NS 1000000

`define PVT_VSW_MIN_LINES 1
`define PVT_VBP_MIN_LINES 2
`define PVT_VFP_MIN_LINES 1
`define PVT_TVB_BASE_LINES 6
`define PVT_TVB_SCALE_LINES 8
`define PVT_HSW_MIN_PCLKS 4
`define PVT_HSW_MAX_PCLKS 128
`define PVT_HBP_MIN_PCLKS 4
`define PVT_HFP_MIN_PCLKS 8

`define PVT_ST_RESET 2'h0
`define PVT_ST_WAIT 2'h1
`define PVT_ST_RUN 2'h2

`define PVT_PIXEL_IDLE 24'h000000

`endif

// ---- rtl/pvt_fifo.v ----
// Parameterised synchronous FIFO with registered full and empty flags
`timescale 1ns/1ps
module pvt_fifo #(
    parameter WIDTH = 24,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire clk_i,
    input wire reset_n_i,
    input wire [WIDTH-1:0] in_data_i,
    input wire in_valid_i,
    output reg in_ready_o,
    output wire [WIDTH-1:0] out_data_o,
    output reg out_valid_o,
    input wire out_ready_i
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] count_reg;
    reg [AW:0] count_next;
    wire push;
    wire pop;

    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem[rd_ptr_reg];

    function [AW-1:0] ptr_inc;
        input [AW-1:0] p;
        begin
            if (p == DEPTH[AW-1:0] - {{(AW-1){1'b0}}, 1'b1})
                ptr_inc = {AW{1'b0}};
            else
                ptr_inc = p + {{(AW-1){1'b0}}, 1'b1};
        end
    endfunction

    always @*
    begin
        count_next = count_reg;
        if (push && !pop)
            count_next = count_reg + {{AW{1'b0}}, 1'b1};
        else if (pop && !push)
            count_next = count_reg - {{AW{1'b0}}, 1'b1};
    end

    always @(posedge clk_i)
    begin
        if (push)
            mem[wr_ptr_reg] <= in_data_i;
    end

    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
            in_ready_o <= 1'b0;
            out_valid_o <= 1'b0;
        end
        else
        begin
            if (push)
                wr_ptr_reg <= ptr_inc(wr_ptr_reg);
            if (pop)
                rd_ptr_reg <= ptr_inc(rd_ptr_reg);
            count_reg <= count_next;
            in_ready_o <= (count_next != DEPTH[AW:0]);
            out_valid_o <= (count_next != {(AW+1){1'b0}});
        end
    end
endmodule // pvt_fifo

// ---- rtl/pvt_video_source.v ----
// Parallel video source: pixel clock, syncs, qualifier, eye select, chip reset
`timescale 1ns/1ps
`include "pvt_timing_map.vh"
// Behaviour
// - Frame sync high at least one line
// - Back porch at least two lines
// - Front porch at least one line
// - Total blanking at least 6+8*max(1,ratio)
// - Line sync high 4 to 128 pclks
// - Four pclks line sync to qualifier
// - Eight pclks qualifier fall to sync
// - Eye select changes 1 ms before sync
// - Eye select stable 1 ms after sync
// - Chip reset held low 1.25 us
// - Reference oscillator 24 MHz within 200 PPM
// - Reference oscillator without spread spectrum
// - Pixel clock jitter within period minus 5.76 ns
module pvt_video_source #(
    parameter H_ACTIVE = 640,
    parameter H_SYNC = 8,
    parameter H_BACK = 8,
    parameter H_FRONT = 16,
    parameter V_ACTIVE = 480,
    parameter V_SYNC = 1,
    parameter V_BACK = 4,
    parameter V_FRONT = 4,
    parameter ARRAY_LINES = 480,
    parameter PCLK_HALF = 1,
    parameter FIFO_DEPTH = 32,
    parameter FIFO_AW = 5,
    parameter EYE_GUARD_CYCLES =
        (`PVT_EYE_GUARD_NS + `PVT_CLK_PERIOD_NS - 1) / `PVT_CLK_PERIOD_NS
) (
    input wire core_clk_i,
    input wire reset_n_i,
    input wire enable_i,
    input wire eye_sel_i,
    input wire [23:0] pixel_data_i,
    input wire pixel_valid_i,
    output wire pixel_ready_o,
    output reg pixel_clk_o,
    output reg frame_sync_o,
    output reg line_sync_o,
    output reg active_data_qualifier_o,
    output reg stereo_eye_select_o,
    output reg [23:0] pixel_bus_o,
    output reg chip_reset_low_o,
    output reg frame_start_o,
    output reg underrun_o
);
    function integer max2;
        input integer a;
        input integer b;
        begin
            max2 = (a > b) ? a : b;
        end
    endfunction

    function integer clamp;
        input integer v;
        input integer lo;
        input integer hi;
        begin
            clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
        end
    endfunction

    function [15:0] cut16;
        input integer v;
        begin
            cut16 = v[15:0];
        end
    endfunction

    function [7:0] cut8;
        input integer v;
        begin
            cut8 = v[7:0];
        end
    endfunction

    function [19:0] cut20;
        input integer v;
        begin
            cut20 = v[19:0];
        end
    endfunction

    localparam integer RESET_CYCLES =
        (`PVT_RESET_LOW_NS + `PVT_CLK_PERIOD_NS - 1) / `PVT_CLK_PERIOD_NS;
    // Sync width kept inside its legal window
    localparam integer HSW = clamp(H_SYNC, `PVT_HSW_MIN_PCLKS, `PVT_HSW_MAX_PCLKS);
    localparam integer HBP = max2(H_BACK, `PVT_HBP_MIN_PCLKS);
    localparam integer HFP = max2(H_FRONT, `PVT_HFP_MIN_PCLKS);
    localparam integer H_TOTAL = HSW + HBP + H_ACTIVE + HFP;
    localparam integer DE_START = HSW + HBP;
    localparam integer DE_END = DE_START + H_ACTIVE;
    localparam integer VSW = max2(V_SYNC, `PVT_VSW_MIN_LINES);
    // Back porch covers the frame sync pulse as well
    localparam integer VBP = max2(max2(V_BACK, `PVT_VBP_MIN_LINES), VSW);
    localparam integer SCALE = max2(`PVT_TVB_SCALE_LINES,
        (`PVT_TVB_SCALE_LINES * V_ACTIVE + ARRAY_LINES - 1) / ARRAY_LINES);
    localparam integer TVB_MIN = `PVT_TVB_BASE_LINES + SCALE;
    localparam integer VFP = max2(max2(V_FRONT, `PVT_VFP_MIN_LINES), TVB_MIN - VBP);
    localparam integer V_TOTAL = VBP + V_ACTIVE + VFP;
    localparam [15:0] H_LAST = cut16(H_TOTAL - 1);
    localparam [15:0] V_LAST = cut16(V_TOTAL - 1);
    localparam [15:0] HSW_W = cut16(HSW);
    localparam [15:0] DE_START_W = cut16(DE_START);
    localparam [15:0] DE_END_W = cut16(DE_END);
    localparam [15:0] VSW_W = cut16(VSW);
    localparam [15:0] VBP_W = cut16(VBP);
    localparam [15:0] VACT_END_W = cut16(VBP + V_ACTIVE);
    localparam [7:0] RESET_LAST = cut8(RESET_CYCLES - 1);
    localparam [7:0] PCLK_LAST = cut8(PCLK_HALF - 1);
    localparam [19:0] EYE_GUARD = cut20(EYE_GUARD_CYCLES);

    reg [1:0] state_reg;
    reg [7:0] rst_cnt_reg;
    reg [7:0] div_cnt_reg;
    reg [15:0] h_cnt_reg;
    reg [15:0] v_cnt_reg;
    reg [19:0] since_vs_reg;
    reg [19:0] since_eye_reg;
    reg running_reg;
    reg enable_meta_reg;
    reg enable_sync_reg;
    reg eye_meta_reg;
    reg eye_sync_reg;
    wire tick;
    wire at_frame_start;
    wire eye_ok;
    wire go;
    wire hs_now;
    wire vs_now;
    wire de_now;
    wire [23:0] fifo_data;
    wire fifo_valid;
    wire fifo_pop;
    wire eye_change;

    // Syncs, qualifier, pixel bus and eye select update only as the pixel clock falls
    assign tick = (state_reg == `PVT_ST_RUN) && pixel_clk_o && (div_cnt_reg == PCLK_LAST);
    assign at_frame_start = (h_cnt_reg == 16'h0000) && (v_cnt_reg == 16'h0000);
    assign eye_ok = (since_eye_reg >= EYE_GUARD) && (since_vs_reg >= EYE_GUARD);
    // Next frame sync edge waits for the eye setup time
    assign go = !at_frame_start || (enable_sync_reg && eye_ok);
    assign hs_now = go && (h_cnt_reg < HSW_W);
    assign vs_now = go && (v_cnt_reg < VSW_W);
    assign de_now = go && (v_cnt_reg >= VBP_W) && (v_cnt_reg < VACT_END_W) &&
        (h_cnt_reg >= DE_START_W) && (h_cnt_reg < DE_END_W);
    assign fifo_pop = tick && de_now;
    // Eye select moves only with frame sync quiet long enough
    assign eye_change = tick && !frame_sync_o && !vs_now && (since_vs_reg >= EYE_GUARD) &&
        (eye_sync_reg != stereo_eye_select_o);

    pvt_fifo #(
        .WIDTH(24),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .in_data_i(pixel_data_i),
        .in_valid_i(pixel_valid_i),
        .in_ready_o(pixel_ready_o),
        .out_data_o(fifo_data),
        .out_valid_o(fifo_valid),
        .out_ready_i(fifo_pop)
    );

    // Two-stage synchronisers for the control inputs
    always @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            enable_meta_reg <= 1'b0;
            enable_sync_reg <= 1'b0;
        end
        else
        begin
            enable_meta_reg <= enable_i;
            enable_sync_reg <= enable_meta_reg;
        end
    end

    always @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            eye_meta_reg <= 1'b0;
            eye_sync_reg <= 1'b0;
        end
        else
        begin
            eye_meta_reg <= eye_sel_i;
            eye_sync_reg <= eye_meta_reg;
        end
    end

    // Reset sequencing and run control
    always @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_reg <= `PVT_ST_RESET;
            rst_cnt_reg <= 8'h00;
            chip_reset_low_o <= 1'b0;
        end
        else
        begin
            case (state_reg)
                `PVT_ST_RESET:
                begin
                    // Hold chip reset low for its full minimum width
                    if (rst_cnt_reg == RESET_LAST)
                    begin
                        chip_reset_low_o <= 1'b1;
                        state_reg <= `PVT_ST_WAIT;
                    end
                    else
                    begin
                        rst_cnt_reg <= rst_cnt_reg + 8'h01;
                    end
                end
                `PVT_ST_WAIT:
                begin
                    if (enable_sync_reg)
                        state_reg <= `PVT_ST_RUN;
                end
                default:
                begin
                    state_reg <= `PVT_ST_RUN;
                end
            endcase
        end
    end

    // Core clock from a fixed reference, no spread
    // Reference accuracy is a board matter
    // Pixel clock divider from the core clock, counting only in the run state
    always @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            div_cnt_reg <= 8'h00;
            pixel_clk_o <= 1'b0;
        end
        else if (state_reg == `PVT_ST_RUN)
        begin
            // Divided clock carries no added period jitter
            if (div_cnt_reg == PCLK_LAST)
            begin
                div_cnt_reg <= 8'h00;
                pixel_clk_o <= !pixel_clk_o;
            end
            else
            begin
                div_cnt_reg <= div_cnt_reg + 8'h01;
            end
        end
    end

    // Line and frame counters with registered sync outputs
    always @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            h_cnt_reg <= 16'h0000;
            v_cnt_reg <= 16'h0000;
            running_reg <= 1'b0;
            frame_sync_o <= 1'b0;
            line_sync_o <= 1'b0;
            active_data_qualifier_o <= 1'b0;
            pixel_bus_o <= `PVT_PIXEL_IDLE;
            frame_start_o <= 1'b0;
            underrun_o <= 1'b0;
        end
        else
        begin
            frame_start_o <= 1'b0;
            underrun_o <= 1'b0;
            if (tick)
            begin
                line_sync_o <= hs_now;
                frame_sync_o <= vs_now;
                active_data_qualifier_o <= de_now;
                pixel_bus_o <= (de_now && fifo_valid) ? fifo_data : `PVT_PIXEL_IDLE;
                underrun_o <= de_now && !fifo_valid;
                if (go)
                begin
                    running_reg <= 1'b1;
                    frame_start_o <= at_frame_start;
                    if (h_cnt_reg == H_LAST)
                    begin
                        h_cnt_reg <= 16'h0000;
                        // Frame length includes the widened blanking
                        if (v_cnt_reg == V_LAST)
                            v_cnt_reg <= 16'h0000;
                        else
                            v_cnt_reg <= v_cnt_reg + 16'h0001;
                    end
                    else
                    begin
                        h_cnt_reg <= h_cnt_reg + 16'h0001;
                    end
                end
            end
        end
    end

    // Eye select guard timers around frame sync edges
    always @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            since_vs_reg <= 20'h00000;
            since_eye_reg <= 20'h00000;
            stereo_eye_select_o <= 1'b0;
        end
        else
        begin
            if (tick && (vs_now != frame_sync_o))
                since_vs_reg <= 20'h00000;
            else if (since_vs_reg < EYE_GUARD)
                since_vs_reg <= since_vs_reg + 20'h00001;
            if (eye_change)
            begin
                stereo_eye_select_o <= eye_sync_reg;
                since_eye_reg <= 20'h00000;
            end
            else if (since_eye_reg < EYE_GUARD)
            begin
                since_eye_reg <= since_eye_reg + 20'h00001;
            end
        end
    end
endmodule // pvt_video_source

// ---- test/pvt_display_model.sv ----
// Behavioural display controller receiving the parallel video link
`timescale 1ns/1ps
module pvt_display_model (
    input wire pixel_clk_i,
    input wire frame_sync_i,
    input wire line_sync_i,
    input wire active_data_qualifier_i,
    input wire chip_reset_low_i,
    input wire [23:0] pixel_bus_i,
    output int n_pix_o,
    output logic [23:0] last_pix_o,
    output int lines_o
);
    int line_cnt;
    logic ls_q, fs_q, has_data;
    // Capture on the rising pixel clock edge
    always @(posedge pixel_clk_i or negedge chip_reset_low_i)
    begin
        if (!chip_reset_low_i) // Held reset while low
        begin
            {n_pix_o, lines_o, line_cnt} <= 96'h0;
            {last_pix_o, ls_q, fs_q, has_data} <= 27'h0;
        end
        else
        begin
            ls_q <= line_sync_i;
            fs_q <= frame_sync_i;
            if (active_data_qualifier_i) // Pixels valid only while qualified
            begin
                n_pix_o <= n_pix_o + 1;
                last_pix_o <= pixel_bus_i;
                has_data <= 1'b1;
            end
            if (line_sync_i && !ls_q && has_data) // Count active lines
            begin
                line_cnt <= line_cnt + 1;
                has_data <= 1'b0;
            end
            if (frame_sync_i && !fs_q)
            begin
                lines_o <= line_cnt;
                line_cnt <= 0;
            end
        end
    end
endmodule // pvt_display_model

// ---- test/pvt_src_asserts.sv ----
// Concurrent checks on the video source link outputs
`timescale 1ns/1ps
module pvt_src_asserts #(
    parameter PCLK_HALF = 1,
    parameter V_ACTIVE = 480,
    parameter ARRAY_LINES = 480,
    parameter EYE_GUARD_CYCLES = 25000
) (
    input wire core_clk_i,
    input wire reset_n_i,
    input wire pixel_ready_o,
    input wire pixel_clk_o,
    input wire frame_sync_o,
    input wire line_sync_o,
    input wire active_data_qualifier_o,
    input wire stereo_eye_select_o,
    input wire [23:0] pixel_bus_o,
    input wire chip_reset_low_o,
    input wire frame_start_o,
    input wire underrun_o
);
    localparam int ST = (8 * V_ACTIVE + ARRAY_LINES - 1) / ARRAY_LINES;
    localparam int TVB = 6 + (ST > 8 ? ST : 8);
    logic [15:0] lsh, lsa, dea, fsh, eya, fsa, rsc, lfs, lde;
    function automatic logic [15:0] inc(input logic [15:0] v);
        return (v == 16'hFFFF) ? v : v + 16'h0001;
    endfunction
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!reset_n_i);
    // Cycle and line counters
    always @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            {lsh, lsa, fsh, rsc, lfs} <= 80'h0;
            {dea, eya, fsa, lde} <= {4{16'hFFFF}};
        end
        else
        begin
            lsh <= line_sync_o ? inc(lsh) : 16'h0000;
            fsh <= frame_sync_o ? inc(fsh) : 16'h0000;
            lsa <= $rose(line_sync_o) ? 16'h0001 : inc(lsa);
            dea <= $fell(active_data_qualifier_o) ? 16'h0001 : inc(dea);
            eya <= $changed(stereo_eye_select_o) ? 16'h0001 : inc(eya);
            fsa <= $changed(frame_sync_o) ? 16'h0001 : inc(fsa);
            rsc <= chip_reset_low_o ? rsc : inc(rsc);
            lfs <= $rose(frame_sync_o) ? 16'h0000 : ($rose(line_sync_o) ? inc(lfs) : lfs);
            lde <= $fell(active_data_qualifier_o) ? 16'h0000 : ($rose(line_sync_o) ? inc(lde) : lde);
        end
    end
    a_vsync_width: assert property ($fell(frame_sync_o) |-> fsh >= lsa)
        else $error("frame sync shorter than a line");
    a_vbp_lines: assert property ($rose(active_data_qualifier_o) |-> lfs >= 2)
        else $error("vertical back porch too short");
    a_vfp_lines: assert property ($rose(frame_sync_o) |-> lde >= 1)
        else $error("vertical front porch too short");
    a_vblank_total: assert property ($rose(active_data_qualifier_o) && lde != 16'h0001 |-> lde >= TVB + 1)
        else $error("total vertical blanking too short");
    a_hsync_width: assert property ($fell(line_sync_o) |-> lsh >= 8 * PCLK_HALF && lsh <= 256 * PCLK_HALF)
        else $error("line sync width out of range");
    a_hbp_gap: assert property ($rose(active_data_qualifier_o) |-> lsa >= 8 * PCLK_HALF)
        else $error("horizontal back porch too short");
    a_hfp_gap: assert property ($rose(line_sync_o) |-> dea >= 16 * PCLK_HALF)
        else $error("horizontal front porch too short");
    a_link_align: assert property ($changed(line_sync_o) || $changed(active_data_qualifier_o) || $changed(pixel_bus_o) |-> $fell(pixel_clk_o))
        else $error("link output moved off the pixel clock fall");
    a_eye_setup: assert property ($changed(frame_sync_o) |-> eya >= EYE_GUARD_CYCLES)
        else $error("eye select changed too close before frame sync");
    a_eye_hold: assert property ($changed(stereo_eye_select_o) |-> fsa >= EYE_GUARD_CYCLES)
        else $error("eye select changed too soon after frame sync");
    a_reset_hold: assert property ($rose(chip_reset_low_o) |-> rsc >= 31)
        else $error("device reset released too early");
    c_frame: cover property (frame_start_o);
    c_under: cover property (underrun_o);
    c_eye: cover property ($changed(stereo_eye_select_o));
    c_full: cover property ($fell(pixel_ready_o));
endmodule // pvt_src_asserts
bind pvt_video_source pvt_src_asserts #(.PCLK_HALF(PCLK_HALF), .V_ACTIVE(V_ACTIVE),
    .ARRAY_LINES(ARRAY_LINES), .EYE_GUARD_CYCLES(EYE_GUARD_CYCLES)) u_chk (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .pixel_ready_o(pixel_ready_o),
    .pixel_clk_o(pixel_clk_o), .frame_sync_o(frame_sync_o), .line_sync_o(line_sync_o),
    .active_data_qualifier_o(active_data_qualifier_o), .underrun_o(underrun_o),
    .stereo_eye_select_o(stereo_eye_select_o), .pixel_bus_o(pixel_bus_o),
    .chip_reset_low_o(chip_reset_low_o), .frame_start_o(frame_start_o));

// ---- test/tb.sv ----
// Self-checking bench for the parallel video source
`timescale 1ns/1ps
module tb;
    logic core_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic enable_i = 1'b0;
    logic eye_sel_i = 1'b0;
    logic pixel_valid_i = 1'b0;
    logic [23:0] pixel_data_i = 24'h000000;
    wire pixel_ready_o, pixel_clk_o, frame_sync_o, line_sync_o, active_data_qualifier_o;
    wire stereo_eye_select_o, chip_reset_low_o, frame_start_o, underrun_o;
    wire [23:0] pixel_bus_o;
    wire [23:0] last_pix;
    int n_pix;
    int lines;
    int miscompares = 0;
    int n_checks = 0;
    always #20 core_clk_i = ~core_clk_i;
    pvt_video_source #(.H_ACTIVE(8), .V_ACTIVE(4), .ARRAY_LINES(4), .EYE_GUARD_CYCLES(20)) dut (
        .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .enable_i(enable_i),
        .eye_sel_i(eye_sel_i), .pixel_data_i(pixel_data_i), .pixel_valid_i(pixel_valid_i),
        .pixel_ready_o(pixel_ready_o), .pixel_clk_o(pixel_clk_o), .frame_sync_o(frame_sync_o),
        .line_sync_o(line_sync_o), .active_data_qualifier_o(active_data_qualifier_o),
        .stereo_eye_select_o(stereo_eye_select_o), .pixel_bus_o(pixel_bus_o),
        .chip_reset_low_o(chip_reset_low_o), .frame_start_o(frame_start_o),
        .underrun_o(underrun_o));
    pvt_display_model u_dev (.pixel_clk_i(pixel_clk_o), .frame_sync_i(frame_sync_o),
        .line_sync_i(line_sync_o), .active_data_qualifier_i(active_data_qualifier_o),
        .chip_reset_low_i(chip_reset_low_o), .pixel_bus_i(pixel_bus_o),
        .n_pix_o(n_pix), .last_pix_o(last_pix), .lines_o(lines));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic ran_out(input logic ok);
        if (ok !== 1'b1)
        begin
            miscompares++;
            $display("MISMATCH %0t wait ran out", $time);
            give_verdict();
        end
    endtask
    task automatic reset_scn;
        repeat (20) @(negedge core_clk_i);
        check(chip_reset_low_o, 1'b0);
        check(pixel_ready_o, 1'b0);
        reset_n_i = 1'b1;
        repeat (30) @(negedge core_clk_i);
        check(chip_reset_low_o, 1'b0);
        repeat (4) @(negedge core_clk_i);
        check(chip_reset_low_o, 1'b1);
    endtask
    task automatic fill_scn;
        int n;
        n = 0;
        pixel_valid_i = 1'b1;
        for (int i = 0; i < 40; i++)
        begin
            pixel_data_i = 24'hA00000 + n[23:0];
            if (pixel_ready_o === 1'b1)
                n++;
            @(negedge core_clk_i);
        end
        pixel_valid_i = 1'b0;
        check(n, 32);
        check(pixel_ready_o, 1'b0);
    endtask
    task automatic stream_scn;
        int i;
        enable_i = 1'b1;
        for (int k = 0; k < 32; k++)
        begin
            for (i = 0; i < 4000 && n_pix == k; i++)
                @(negedge core_clk_i);
            ran_out(n_pix == k + 1);
            check(last_pix, 24'hA00000 + k[23:0]);
        end
        check(pixel_ready_o, 1'b1);
    endtask
    task automatic underrun_scn;
        int i;
        int n;
        for (i = 0; i < 4000 && underrun_o !== 1'b1; i++)
            @(negedge core_clk_i);
        ran_out(underrun_o === 1'b1);
        n = n_pix;
        for (i = 0; i < 8 && n_pix == n; i++)
            @(negedge core_clk_i);
        check(last_pix, 24'h000000);
        check(lines, 4);
    endtask
    task automatic eye_scn;
        int i;
        eye_sel_i = 1'b1;
        for (i = 0; i < 8000 && stereo_eye_select_o !== 1'b1; i++)
            @(negedge core_clk_i);
        check(stereo_eye_select_o, 1'b1);
        eye_sel_i = 1'b0;
        for (i = 0; i < 8000 && stereo_eye_select_o !== 1'b0; i++)
            @(negedge core_clk_i);
        check(stereo_eye_select_o, 1'b0);
        for (i = 0; i < 8000 && frame_start_o !== 1'b1; i++)
            @(negedge core_clk_i);
        ran_out(frame_start_o === 1'b1);
    endtask
    initial
    begin
        reset_scn();
        fill_scn();
        stream_scn();
        underrun_scn();
        eye_scn();
        give_verdict();
    end
endmodule // tb
